// ===== rtl/osp_pkg.sv
// package: register map, field layout, reset values and source codes
package osp_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [15:0] OSP_ADDR_SYNC     = 16'h00a8;
	localparam logic [15:0] OSP_ADDR_SEL45    = 16'h00a9;
	localparam logic [15:0] OSP_ADDR_SEL67    = 16'h00aa;
	localparam logic [15:0] OSP_ADDR_FIXED    = 16'h00ab;
	localparam logic [15:0] OSP_ADDR_LOOPFILT = 16'h00ac;
	localparam logic [15:0] OSP_ADDR_MODELOCK = 16'h00ad;
	localparam logic [15:0] OSP_ADDR_VCO1     = 16'h00ae;
	localparam logic [15:0] OSP_ADDR_VCO2     = 16'h00af;

	// ************************************************************
	// field positions (low bit of each field)
	// ************************************************************
	localparam int OSP_SYNC_BIT      = 5;
	localparam int OSP_SEL_LO_POS    = 0;
	localparam int OSP_SEL_HI_POS    = 4;
	localparam int OSP_CPCUR_POS     = 5;
	localparam int OSP_RSER_POS      = 3;
	localparam int OSP_CPAR_POS      = 1;
	localparam int OSP_POLE_BIT      = 0;
	localparam int OSP_SYNMODE_BIT   = 3;
	localparam int OSP_LOCKCNT_BIT   = 1;
	localparam int OSP_OVERRIDE_BIT  = 0;
	localparam int OSP_VCOSEL_BIT    = 5;
	localparam int OSP_LOCKVAL_POS   = 0;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [2:0] OSP_RST_SEL4    = 3'h0;
	localparam logic [2:0] OSP_RST_SEL5    = 3'h2;
	localparam logic [2:0] OSP_RST_SEL6    = 3'h0;
	localparam logic [2:0] OSP_RST_SEL7    = 3'h5;
	localparam logic [2:0] OSP_RST_CPCUR   = 3'h4;
	localparam logic [1:0] OSP_RST_RSER    = 2'h1;
	localparam logic [1:0] OSP_RST_CPAR    = 2'h1;
	localparam logic       OSP_RST_POLE    = 1'h1;
	localparam logic       OSP_RST_LOCKCNT = 1'h1;
	localparam logic       OSP_RST_OVERRD  = 1'h0;
	localparam logic       OSP_RST_VCOSEL  = 1'h1;
	localparam logic [4:0] OSP_RST_LOCK1   = 5'h0b;
	localparam logic [4:0] OSP_RST_LOCK2   = 5'h00;
	localparam logic       OSP_RST_SYNMODE = 1'h0;
	localparam logic       OSP_RST_SYNC    = 1'h0;
	localparam logic [7:0] OSP_FIXED_VALUE = 8'hf0;

	// ************************************************************
	// source select codes
	// ************************************************************
	localparam logic [2:0] OSP_SRC_PLL  = 3'h0;
	localparam logic [2:0] OSP_SRC_RSV1 = 3'h1;
	localparam logic [2:0] OSP_SRC_OUT2 = 3'h2;
	localparam logic [2:0] OSP_SRC_OUT3 = 3'h3;
	localparam logic [2:0] OSP_SRC_REF0 = 3'h4;
	localparam logic [2:0] OSP_SRC_REF1 = 3'h5;
	localparam logic [2:0] OSP_SRC_RSV6 = 3'h6;
	localparam logic [2:0] OSP_SRC_XTAL = 3'h7;

	// one-hot route bit positions
	localparam int OSP_ROUTE_PLL  = 0;
	localparam int OSP_ROUTE_OUT2 = 1;
	localparam int OSP_ROUTE_OUT3 = 2;
	localparam int OSP_ROUTE_REF0 = 3;
	localparam int OSP_ROUTE_REF1 = 4;
	localparam int OSP_ROUTE_XTAL = 5;
	localparam int OSP_ROUTE_W    = 6;

endpackage

// ===== rtl/osp_source_route.sv
// source select decoder for one output: code to registered one-hot route
`timescale 1ns/1ps
module osp_source_route (
	// clock and reset
	input  wire logic                            clock,
	input  wire logic                            srst,
	// select code
	input  wire logic [2:0]                      sourceCode,
	// route
	output logic      [osp_pkg::OSP_ROUTE_W-1:0] route,
	output logic                                 routeReserved
);
	import osp_pkg::*;

	// ************************************************************
	// decode
	// ************************************************************
	logic [OSP_ROUTE_W-1:0] route_nxt;
	logic                   reserved_nxt;

	always_comb begin
		route_nxt    = '0;
		reserved_nxt = 1'b0;
		unique case (sourceCode)
			OSP_SRC_PLL:  route_nxt[OSP_ROUTE_PLL]  = 1'b1;
			OSP_SRC_OUT2: route_nxt[OSP_ROUTE_OUT2] = 1'b1;
			OSP_SRC_OUT3: route_nxt[OSP_ROUTE_OUT3] = 1'b1;
			OSP_SRC_REF0: route_nxt[OSP_ROUTE_REF0] = 1'b1;
			OSP_SRC_REF1: route_nxt[OSP_ROUTE_REF1] = 1'b1;
			OSP_SRC_XTAL: route_nxt[OSP_ROUTE_XTAL] = 1'b1;
			// reserved codes route nothing rather than guess a source
			OSP_SRC_RSV1,
			OSP_SRC_RSV6: reserved_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			route         <= '0;
			routeReserved <= 1'b0;
		end else begin
			route         <= route_nxt;
			routeReserved <= reserved_nxt;
		end
	end

endmodule // osp_source_route

// ===== rtl/osp_output_source_pll_cfg.sv
// output source select, divider sync and pll loop configuration registers
// Operation
// - sync rising holds pll-fed dividers in reset
// - sync falling releases together, coarse phase cleared
// - source codes route pll, q2, q3, refs, crystal
// - source fields reset to pll, q2, pll, ref1
// - reserved bits written zero, read undefined
// - synth mode: crystal only, software forces freerun
// - override bit selects automatic or manual lock
// - vco select: zero second, one first
// - two manual lock values, reset 01011, 00000
// - lock count: 1 ppm or 16 ppm
// - store loop filter codes, drive analog loop
// - any sync toggle clears coarse phase values
`timescale 1ns/1ps
module osp_output_source_pll_cfg (
	// clock and reset
	input  wire logic                            clock,
	input  wire logic                            srst,
	// management register port
	input  wire logic [15:0]                     regAddr,
	input  wire logic [7:0]                      regWrData,
	input  wire logic                            regWrEn,
	input  wire logic                            regRdEn,
	output logic      [7:0]                      regRdData,
	output logic                                 regRdValid,
	// output source routes, outputs four to seven
	output logic      [osp_pkg::OSP_ROUTE_W-1:0] out4Route,
	output logic      [osp_pkg::OSP_ROUTE_W-1:0] out5Route,
	output logic      [osp_pkg::OSP_ROUTE_W-1:0] out6Route,
	output logic      [osp_pkg::OSP_ROUTE_W-1:0] out7Route,
	output logic      [3:0]                      outRouteReserved,
	// divider synchronisation
	output logic      [3:0]                      outDividerReset,
	output logic                                 coarsePhaseClear,
	// analog loop settings
	output logic      [2:0]                      chargePumpCurrent,
	output logic      [1:0]                      loopSeriesResistor,
	output logic      [1:0]                      loopParallelCapacitor,
	output logic                                 secondPoleSelect,
	// digital lock and mode settings
	output logic                                 lockCountAccuracy,
	output logic                                 lockManualOverride,
	output logic                                 manualVcoSelect,
	output logic      [4:0]                      vcoFirstLockValue,
	output logic      [4:0]                      vcoSecondLockValue,
	output logic                                 synthesizerMode
);
	import osp_pkg::*;

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic [2:0] sel4_r, sel4_nxt;
	logic [2:0] sel5_r, sel5_nxt;
	logic [2:0] sel6_r, sel6_nxt;
	logic [2:0] sel7_r, sel7_nxt;
	logic       sync_r, sync_nxt;
	logic [2:0] cpCur_r, cpCur_nxt;
	logic [1:0] rSer_r, rSer_nxt;
	logic [1:0] cPar_r, cPar_nxt;
	logic       pole_r, pole_nxt;
	logic       lockCnt_r, lockCnt_nxt;
	logic       overrd_r, overrd_nxt;
	logic       vcoSel_r, vcoSel_nxt;
	logic [4:0] lock1_r, lock1_nxt;
	logic [4:0] lock2_r, lock2_nxt;
	logic       synMode_r, synMode_nxt;

	// only the defined field bits are stored; reserved bits are dropped
	always_comb begin
		sel4_nxt    = sel4_r;
		sel5_nxt    = sel5_r;
		sel6_nxt    = sel6_r;
		sel7_nxt    = sel7_r;
		sync_nxt    = sync_r;
		cpCur_nxt   = cpCur_r;
		rSer_nxt    = rSer_r;
		cPar_nxt    = cPar_r;
		pole_nxt    = pole_r;
		lockCnt_nxt = lockCnt_r;
		overrd_nxt  = overrd_r;
		vcoSel_nxt  = vcoSel_r;
		lock1_nxt   = lock1_r;
		lock2_nxt   = lock2_r;
		synMode_nxt = synMode_r;
		if (regWrEn) begin
			unique case (regAddr)
				OSP_ADDR_SYNC: sync_nxt = regWrData[OSP_SYNC_BIT];
				OSP_ADDR_SEL45: begin
					sel4_nxt = regWrData[OSP_SEL_LO_POS +: 3];
					sel5_nxt = regWrData[OSP_SEL_HI_POS +: 3];
				end
				OSP_ADDR_SEL67: begin
					sel6_nxt = regWrData[OSP_SEL_LO_POS +: 3];
					sel7_nxt = regWrData[OSP_SEL_HI_POS +: 3];
				end
				OSP_ADDR_LOOPFILT: begin
					cpCur_nxt = regWrData[OSP_CPCUR_POS +: 3];
					rSer_nxt  = regWrData[OSP_RSER_POS +: 2];
					cPar_nxt  = regWrData[OSP_CPAR_POS +: 2];
					pole_nxt  = regWrData[OSP_POLE_BIT];
				end
				OSP_ADDR_MODELOCK: begin
					synMode_nxt = regWrData[OSP_SYNMODE_BIT];
					lockCnt_nxt = regWrData[OSP_LOCKCNT_BIT];
					overrd_nxt  = regWrData[OSP_OVERRIDE_BIT];
				end
				OSP_ADDR_VCO1: begin
					vcoSel_nxt = regWrData[OSP_VCOSEL_BIT];
					lock1_nxt  = regWrData[OSP_LOCKVAL_POS +: 5];
				end
				OSP_ADDR_VCO2: lock2_nxt = regWrData[OSP_LOCKVAL_POS +: 5];
				default: ; // fixed register and unmapped addresses ignore writes
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			sel4_r    <= OSP_RST_SEL4;
			sel5_r    <= OSP_RST_SEL5;
			sel6_r    <= OSP_RST_SEL6;
			sel7_r    <= OSP_RST_SEL7;
			sync_r    <= OSP_RST_SYNC;
			cpCur_r   <= OSP_RST_CPCUR;
			rSer_r    <= OSP_RST_RSER;
			cPar_r    <= OSP_RST_CPAR;
			pole_r    <= OSP_RST_POLE;
			lockCnt_r <= OSP_RST_LOCKCNT;
			overrd_r  <= OSP_RST_OVERRD;
			vcoSel_r  <= OSP_RST_VCOSEL;
			lock1_r   <= OSP_RST_LOCK1;
			lock2_r   <= OSP_RST_LOCK2;
			synMode_r <= OSP_RST_SYNMODE;
		end else begin
			sel4_r    <= sel4_nxt;
			sel5_r    <= sel5_nxt;
			sel6_r    <= sel6_nxt;
			sel7_r    <= sel7_nxt;
			sync_r    <= sync_nxt;
			cpCur_r   <= cpCur_nxt;
			rSer_r    <= rSer_nxt;
			cPar_r    <= cPar_nxt;
			pole_r    <= pole_nxt;
			lockCnt_r <= lockCnt_nxt;
			overrd_r  <= overrd_nxt;
			vcoSel_r  <= vcoSel_nxt;
			lock1_r   <= lock1_nxt;
			lock2_r   <= lock2_nxt;
			synMode_r <= synMode_nxt;
		end
	end

	// ************************************************************
	// readback
	// ************************************************************
	logic [7:0] rdData_r, rdData_nxt;
	logic       rdValid_r, rdValid_nxt;

	// reserved bits read as zero, which the undefined readback permits
	always_comb begin
		rdData_nxt  = rdData_r;
		rdValid_nxt = regRdEn;
		if (regRdEn) begin
			rdData_nxt = 8'h00;
			unique case (regAddr)
				OSP_ADDR_SYNC: rdData_nxt[OSP_SYNC_BIT] = sync_r;
				OSP_ADDR_SEL45: begin
					rdData_nxt[OSP_SEL_LO_POS +: 3] = sel4_r;
					rdData_nxt[OSP_SEL_HI_POS +: 3] = sel5_r;
				end
				OSP_ADDR_SEL67: begin
					rdData_nxt[OSP_SEL_LO_POS +: 3] = sel6_r;
					rdData_nxt[OSP_SEL_HI_POS +: 3] = sel7_r;
				end
				OSP_ADDR_FIXED: rdData_nxt = OSP_FIXED_VALUE;
				OSP_ADDR_LOOPFILT: begin
					rdData_nxt[OSP_CPCUR_POS +: 3] = cpCur_r;
					rdData_nxt[OSP_RSER_POS +: 2]  = rSer_r;
					rdData_nxt[OSP_CPAR_POS +: 2]  = cPar_r;
					rdData_nxt[OSP_POLE_BIT]       = pole_r;
				end
				OSP_ADDR_MODELOCK: begin
					rdData_nxt[OSP_SYNMODE_BIT]  = synMode_r;
					rdData_nxt[OSP_LOCKCNT_BIT]  = lockCnt_r;
					rdData_nxt[OSP_OVERRIDE_BIT] = overrd_r;
				end
				OSP_ADDR_VCO1: begin
					rdData_nxt[OSP_VCOSEL_BIT]       = vcoSel_r;
					rdData_nxt[OSP_LOCKVAL_POS +: 5] = lock1_r;
				end
				OSP_ADDR_VCO2: rdData_nxt[OSP_LOCKVAL_POS +: 5] = lock2_r;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdData_r  <= 8'h00;
			rdValid_r <= 1'b0;
		end else begin
			rdData_r  <= rdData_nxt;
			rdValid_r <= rdValid_nxt;
		end
	end

	// ************************************************************
	// divider synchronisation
	// ************************************************************
	logic [3:0] divHold_r, divHold_nxt;
	logic       phClr_r, phClr_nxt;
	logic [3:0] pllFed;

	assign pllFed = {sel7_r == OSP_SRC_PLL, sel6_r == OSP_SRC_PLL,
		sel5_r == OSP_SRC_PLL, sel4_r == OSP_SRC_PLL};

	// the held set is latched at the rising edge so that a source change
	// while held cannot release one divider early and break alignment
	always_comb begin
		divHold_nxt = divHold_r;
		if (!sync_r && sync_nxt) begin
			divHold_nxt = pllFed;
		end else if (sync_r && !sync_nxt) begin
			divHold_nxt = 4'h0;
		end
		phClr_nxt = sync_r ^ sync_nxt;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			divHold_r <= 4'h0;
			phClr_r   <= 1'b0;
		end else begin
			divHold_r <= divHold_nxt;
			phClr_r   <= phClr_nxt;
		end
	end

	// ************************************************************
	// source decoders
	// ************************************************************
	osp_source_route u_route4 (
		.clock         (clock),
		.srst          (srst),
		.sourceCode    (sel4_r),
		.route         (out4Route),
		.routeReserved (outRouteReserved[0])
	);

	osp_source_route u_route5 (
		.clock         (clock),
		.srst          (srst),
		.sourceCode    (sel5_r),
		.route         (out5Route),
		.routeReserved (outRouteReserved[1])
	);

	osp_source_route u_route6 (
		.clock         (clock),
		.srst          (srst),
		.sourceCode    (sel6_r),
		.route         (out6Route),
		.routeReserved (outRouteReserved[2])
	);

	osp_source_route u_route7 (
		.clock         (clock),
		.srst          (srst),
		.sourceCode    (sel7_r),
		.route         (out7Route),
		.routeReserved (outRouteReserved[3])
	);

	// ************************************************************
	// outputs
	// ************************************************************
	assign regRdData             = rdData_r;
	assign regRdValid            = rdValid_r;
	assign outDividerReset       = divHold_r;
	assign coarsePhaseClear      = phClr_r;
	assign chargePumpCurrent     = cpCur_r;
	assign loopSeriesResistor    = rSer_r;
	assign loopParallelCapacitor = cPar_r;
	assign secondPoleSelect      = pole_r;
	assign lockCountAccuracy     = lockCnt_r;
	assign lockManualOverride    = overrd_r;
	assign manualVcoSelect       = vcoSel_r;
	assign vcoFirstLockValue     = lock1_r;
	assign vcoSecondLockValue    = lock2_r;
	// crystal-only reference choice is made by the analog loop from this level
	assign synthesizerMode       = synMode_r;

endmodule // osp_output_source_pll_cfg

// ===== bench/osp_output_source_pll_cfg_assertions.sv
// checker: register port timing, field updates, route flags and divider sync relations
`timescale 1ns/1ps
module osp_output_source_pll_cfg_assertions (
	// clock and reset
	input wire logic                            clock,
	input wire logic                            srst,
	// register port
	input wire logic [15:0]                     regAddr,
	input wire logic [7:0]                      regWrData,
	input wire logic                            regWrEn,
	input wire logic                            regRdEn,
	input wire logic [7:0]                      regRdData,
	input wire logic                            regRdValid,
	// watched outputs
	input wire logic [osp_pkg::OSP_ROUTE_W-1:0] out4Route,
	input wire logic [3:0]                      outRouteReserved,
	input wire logic [3:0]                      outDividerReset,
	input wire logic                            coarsePhaseClear,
	input wire logic [2:0]                      chargePumpCurrent,
	input wire logic [1:0]                      loopSeriesResistor,
	input wire logic [1:0]                      loopParallelCapacitor,
	input wire logic                            secondPoleSelect,
	input wire logic                            synthesizerMode
);
	import osp_pkg::*;
	// ********
	// properties
	// ********
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	logic [7:0] loopCfg;
	assign loopCfg = {chargePumpCurrent, loopSeriesResistor, loopParallelCapacitor, secondPoleSelect};
	property p_rd_valid; regRdEn |=> regRdValid; endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
	property p_rd_quiet; !regRdEn |=> !regRdValid; endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("valid without read");
	property p_rd_loop; regRdEn && regAddr == OSP_ADDR_LOOPFILT |=> regRdData == $past(loopCfg);
	endproperty
	a_rd_loop: assert property (p_rd_loop) else $error("loop readback wrong");
	property p_rd_unmapped; regRdEn && regAddr == 16'h0000 |=> regRdData == 8'h00; endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	property p_wr_loop; regWrEn && regAddr == OSP_ADDR_LOOPFILT |=> loopCfg == $past(regWrData);
	endproperty
	a_wr_loop: assert property (p_wr_loop) else $error("loop write lost");
	property p_hold_loop; !(regWrEn && regAddr == OSP_ADDR_LOOPFILT) |=> $stable(loopCfg);
	endproperty
	a_hold_loop: assert property (p_hold_loop) else $error("loop field drifted");
	property p_wr_mode; regWrEn && regAddr == OSP_ADDR_MODELOCK |=>
		synthesizerMode == $past(regWrData[3]); endproperty
	a_wr_mode: assert property (p_wr_mode) else $error("synth mode write lost");
	// back-to-back sync writes may legally pulse twice, so only a quiet cycle must end it
	property p_clr_pulse; coarsePhaseClear && !(regWrEn && regAddr == OSP_ADDR_SYNC) |=>
		!coarsePhaseClear; endproperty
	a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
	property p_hold_start; $rose(|outDividerReset) |-> coarsePhaseClear; endproperty
	a_hold_start: assert property (p_hold_start) else $error("hold without clear");
	property p_release; (|$past(outDividerReset)) && outDividerReset != $past(outDividerReset)
		|-> outDividerReset == 4'h0 && coarsePhaseClear; endproperty
	a_release: assert property (p_release) else $error("partial release");
	property p_sync_low; regWrEn && regAddr == OSP_ADDR_SYNC && !regWrData[5] |=>
		outDividerReset == 4'h0; endproperty
	a_sync_low: assert property (p_sync_low) else $error("dividers still held");
	property p_route_rsv; outRouteReserved[0] |-> out4Route == '0; endproperty
	a_route_rsv: assert property (p_route_rsv) else $error("reserved code routed");
endmodule // osp_output_source_pll_cfg_assertions

bind osp_output_source_pll_cfg osp_output_source_pll_cfg_assertions chk_i (
	.clock(clock), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
	.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
	.out4Route(out4Route), .outRouteReserved(outRouteReserved),
	.outDividerReset(outDividerReset), .coarsePhaseClear(coarsePhaseClear),
	.chargePumpCurrent(chargePumpCurrent), .loopSeriesResistor(loopSeriesResistor),
	.loopParallelCapacitor(loopParallelCapacitor), .secondPoleSelect(secondPoleSelect),
	.synthesizerMode(synthesizerMode)
);

// ===== bench/osp_output_source_pll_cfg_test.sv
// testbench: register access sequences with expected values
`timescale 1ns/1ps
module osp_output_source_pll_cfg_test;
	import osp_pkg::*;
	logic                   clock = 1'b0;
	logic                   srst = 1'b1;
	logic [15:0]            regAddr = 16'h0000;
	logic [7:0]             regWrData = 8'h00;
	logic                   regWrEn = 1'b0;
	logic                   regRdEn = 1'b0;
	logic [7:0]             regRdData;
	logic                   regRdValid;
	logic [OSP_ROUTE_W-1:0] out4Route, out5Route, out6Route, out7Route;
	logic [3:0]             outRouteReserved, outDividerReset;
	logic                   coarsePhaseClear, secondPoleSelect, synthesizerMode;
	logic [2:0]             chargePumpCurrent;
	logic [1:0]             loopSeriesResistor, loopParallelCapacitor;
	logic                   lockCountAccuracy, lockManualOverride, manualVcoSelect;
	logic [4:0]             vcoFirstLockValue, vcoSecondLockValue;
	int                     fails = 0;
	int                     checksDone = 0;
	// reset image: unmapped places read zero, full 16-bit decode
	logic [15:0] dA [10] = '{16'h00a8, 16'h00a9, 16'h00aa, 16'h00ab, 16'h00ac, 16'h00ad,
		16'h00ae, 16'h00af, 16'h0000, 16'h01ac};
	logic [7:0]  dV [10] = '{8'h00, 8'h20, 8'h50, 8'hf0, 8'h8b, 8'h02, 8'h2b, 8'h00, 8'h00, 8'h00};

	always #2.5 clock = ~clock;

	osp_output_source_pll_cfg osp_output_source_pll_cfg_i (
		.clock(clock), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
		.out4Route(out4Route), .out5Route(out5Route), .out6Route(out6Route),
		.out7Route(out7Route), .outRouteReserved(outRouteReserved),
		.outDividerReset(outDividerReset), .coarsePhaseClear(coarsePhaseClear),
		.chargePumpCurrent(chargePumpCurrent), .loopSeriesResistor(loopSeriesResistor),
		.loopParallelCapacitor(loopParallelCapacitor), .secondPoleSelect(secondPoleSelect),
		.lockCountAccuracy(lockCountAccuracy), .lockManualOverride(lockManualOverride),
		.manualVcoSelect(manualVcoSelect), .vcoFirstLockValue(vcoFirstLockValue),
		.vcoSecondLockValue(vcoSecondLockValue), .synthesizerMode(synthesizerMode)
	);

	// ********
	// access and check tasks
	// ********
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// ends just after the taking edge so callers see the updated fields
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clock);
		regWrEn <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		int n;
		@(posedge clock);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clock);
		regRdEn <= 1'b0;
		#1;
		n = 0;
		while (regRdValid !== 1'b1 && n < 4) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n == 4) begin
			fails++;
			$display("[ERR] regRdValid expected 1 seen 0");
			wrapUp();
		end else begin
			chk($sformatf("read %h", a), exp, regRdData);
		end
	endtask
	task automatic doReset();
		@(posedge clock);
		srst <= 1'b1;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
	endtask
	task automatic chkDefaults();
		for (int i = 0; i < 10; i++) rd(dA[i], dV[i]);
		chk("out4Route", 8'h01, {2'h0, out4Route});
		chk("out5Route", 8'h02, {2'h0, out5Route});
		chk("out6Route", 8'h01, {2'h0, out6Route});
		chk("out7Route", 8'h10, {2'h0, out7Route});
	endtask
	function automatic logic [5:0] routeOf(input logic [2:0] c);
		case (c)
			3'h0: routeOf = 6'h01;
			3'h2: routeOf = 6'h02;
			3'h3: routeOf = 6'h04;
			3'h4: routeOf = 6'h08;
			3'h5: routeOf = 6'h10;
			3'h7: routeOf = 6'h20;
			default: routeOf = 6'h00;
		endcase
	endfunction

	// ********
	// main sequence
	// ********
	initial begin
		doReset();
		chkDefaults();
		wr(OSP_ADDR_LOOPFILT, 8'h55);
		rd(OSP_ADDR_LOOPFILT, 8'h55);
		chk("loop", 8'h55, {chargePumpCurrent, loopSeriesResistor, loopParallelCapacitor,
			secondPoleSelect});
		wr(OSP_ADDR_MODELOCK, 8'hff);
		rd(OSP_ADDR_MODELOCK, 8'h0b);
		chk("mode", 8'h07, {5'h0, synthesizerMode, lockCountAccuracy, lockManualOverride});
		wr(OSP_ADDR_VCO1, 8'hff);
		chk("vco1", 8'h3f, {2'h0, manualVcoSelect, vcoFirstLockValue});
		wr(OSP_ADDR_VCO2, 8'hff);
		chk("vco2", 8'h1f, {3'h0, vcoSecondLockValue});
		wr(OSP_ADDR_FIXED, 8'h00);
		rd(OSP_ADDR_FIXED, 8'hf0);
		wr(OSP_ADDR_MODELOCK, 8'h00);
		wr(OSP_ADDR_VCO1, 8'h00);
		chk("mode0", 8'h00, {5'h0, synthesizerMode, lockCountAccuracy, lockManualOverride});
		chk("vcosel0", 8'h00, {7'h0, manualVcoSelect});
		// reference codes are only routed here, no reference clock runs in this bench
		for (int c = 0; c < 8; c++) begin
			wr(OSP_ADDR_SEL45, {1'b0, c[2:0], 1'b0, c[2:0]});
			wr(OSP_ADDR_SEL67, {1'b0, c[2:0], 1'b0, c[2:0]});
			@(posedge clock);
			#1;
			chk("out4Route", {2'h0, routeOf(c[2:0])}, {2'h0, out4Route});
			chk("out5Route", {2'h0, routeOf(c[2:0])}, {2'h0, out5Route});
			chk("out6Route", {2'h0, routeOf(c[2:0])}, {2'h0, out6Route});
			chk("out7Route", {2'h0, routeOf(c[2:0])}, {2'h0, out7Route});
			chk("reserved", (c == 1 || c == 6) ? 8'h0f : 8'h00, {4'h0, outRouteReserved});
		end
		// only pll-fed outputs four and five are held
		wr(OSP_ADDR_SEL45, 8'h00);
		wr(OSP_ADDR_SEL67, 8'h75);
		wr(OSP_ADDR_SYNC, 8'h20);
		chk("divReset", 8'h03, {4'h0, outDividerReset});
		chk("clear", 8'h01, {7'h0, coarsePhaseClear});
		wr(OSP_ADDR_SEL45, 8'h77);
		chk("divKept", 8'h03, {4'h0, outDividerReset});
		rd(OSP_ADDR_SYNC, 8'h20);
		wr(OSP_ADDR_SYNC, 8'h00);
		chk("divRelease", 8'h00, {4'h0, outDividerReset});
		chk("clear", 8'h01, {7'h0, coarsePhaseClear});
		@(posedge clock);
		#1;
		chk("clearEnd", 8'h00, {7'h0, coarsePhaseClear});
		wr(OSP_ADDR_SEL67, 8'h00);
		wr(OSP_ADDR_SYNC, 8'h20);
		chk("divReset", 8'h0c, {4'h0, outDividerReset});
		// reset in mid-hold must drop the held set as well
		doReset();
		@(posedge clock);
		#1;
		chk("divAfterRst", 8'h00, {4'h0, outDividerReset});
		chkDefaults();
		wrapUp();
	end
endmodule // osp_output_source_pll_cfg_test
